// *** hw/lca_pkg.sv ***
// Purpose: shared constants and types of the logic and compare datapath
// Assumes: byte-wide operands, 16-bit memory addresses
// Notes:   every window bound and datapath reset value lives here, with the borrow bit positions; done and error reset to 1'b0 in lca_exec
package lca_pkg;

  localparam int          DATA_W      = 8;
  localparam int          ADDR_W      = 16;
  localparam int          NIB_W       = 4;

  // Short direct window, inclusive bounds
  localparam logic [15:0] SADDR_LO    = 16'hfe20;
  localparam logic [15:0] SADDR_HI    = 16'hff1f;
  // Fixed page for page-offset indirect access
  localparam logic [7:0]  PAGE_HI     = 8'hfe;

  localparam logic [7:0]  BYTE_RST    = 8'h00;
  localparam logic [15:0] ADDR_RST    = 16'h0000;
  localparam logic        FLAG_RST    = 1'b0;

  typedef enum logic [1:0] {
    OP_AND     = 2'h0,
    OP_OR      = 2'h1,
    OP_XOR     = 2'h2,
    COMPARE_OP = 2'h3
  } lca_op_type;

  typedef enum logic [3:0] {
    M_IMM       = 4'h0,  // A, #byte
    M_REG       = 4'h1,  // r, r'
    M_SADDR_SRC = 4'h2,  // A, saddr
    M_SFR_SRC   = 4'h3,  // A, sfr
    M_PAGE      = 4'h4,  // A, [page_offset_register]
    M_PTR1      = 4'h5,  // A, [pointer_pair_one]
    M_PTR2      = 4'h6,  // A, [pointer_pair_two]
    M_INDEX     = 4'h7,  // A, word[index_register]
    M_SADDR_DST = 4'h8,  // saddr, #byte
    M_SFR_DST   = 4'h9   // sfr, #byte
  } lca_mode_type;

  typedef enum logic [2:0] {
    DST_NONE = 3'h0,
    DST_ACC  = 3'h1,
    DST_REG  = 3'h2,
    DST_SFR  = 3'h3,
    DST_MEM  = 3'h4
  } lca_dest_type;

  // Gray order along idle, fetch, execute, store
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_EXEC  = 2'b11,
    ST_STORE = 2'b10
  } lca_state_type;

  function automatic logic lca_in_saddr(input logic [15:0] addr);
    lca_in_saddr = (addr >= SADDR_LO) && (addr <= SADDR_HI);
  endfunction : lca_in_saddr

  function automatic logic lca_is_mem(input lca_mode_type mode);
    lca_is_mem = (mode == M_SADDR_SRC) || (mode == M_PAGE) || (mode == M_PTR1) ||
                 (mode == M_PTR2) || (mode == M_INDEX) || (mode == M_SADDR_DST);
  endfunction : lca_is_mem

endpackage : lca_pkg

// *** hw/lca_alu_if.sv ***
// Purpose: carries one operation between the sequencer and the arithmetic core
// Assumes: purely combinational path, one clock domain
// Notes:   core modport computes, user modport drives operands
`timescale 1ns/100ps
`default_nettype none
interface lca_alu_if;
  lca_pkg::lca_op_type op;
  logic [7:0]          opa;
  logic [7:0]          opb;
  logic [7:0]          res;
  logic                zero;
  logic                half_borrow;
  logic                borrow;
  logic                upd_carries;

  modport core (input op, input opa, input opb,
                output res, output zero, output half_borrow, output borrow,
                output upd_carries);
  modport user (output op, output opa, output opb,
                input res, input zero, input half_borrow, input borrow,
                input upd_carries);
endinterface : lca_alu_if
`default_nettype wire

// *** hw/lca_alu_core.sv ***
// Purpose: bitwise and compare arithmetic on two bytes
// Assumes: operands stable for the whole evaluating cycle
// Notes:   compare result is the difference, never written back by the caller
`timescale 1ns/100ps
`default_nettype none
module lca_alu_core (
  // Operation and result
  lca_alu_if.core alu
);

  logic [8:0] diff;
  logic [4:0] low_diff;

  always_comb begin
    diff     = {1'b0, alu.opa} - {1'b0, alu.opb};
    low_diff = {1'b0, alu.opa[3:0]} - {1'b0, alu.opb[3:0]};
    unique case (alu.op)
      lca_pkg::OP_AND: alu.res = alu.opa & alu.opb;
      lca_pkg::OP_OR:  alu.res = alu.opa | alu.opb;
      lca_pkg::OP_XOR: alu.res = alu.opa ^ alu.opb;
      lca_pkg::COMPARE_OP: alu.res = diff[7:0];
    endcase
    alu.zero        = (alu.res == lca_pkg::BYTE_RST);
    alu.half_borrow = low_diff[lca_pkg::NIB_W];
    alu.borrow      = diff[lca_pkg::DATA_W];
    alu.upd_carries = (alu.op == lca_pkg::COMPARE_OP);
  end

endmodule : lca_alu_core
`default_nettype wire

// *** hw/lca_exec.sv ***
// Purpose: sequencer of byte logic and compare operations with flag keeping
// Assumes: memory port answers with a one-cycle ack, same clock as the core
// Notes:   register operands are sampled when a request is taken
`timescale 1ns/100ps
`default_nettype none
module lca_exec (
  // Clock and reset
  input  wire  logic                  clk_i,
  input  wire  logic                  nrst_i,
  // Request
  input  wire  logic                  req_valid_i,
  output logic                        req_ready_o,
  input  wire  lca_pkg::lca_op_type   req_op_i,
  input  wire  lca_pkg::lca_mode_type req_mode_i,
  input  wire  logic [7:0]            req_imm_i,
  input  wire  logic [15:0]           req_word_i,
  // Operand values from the register file
  input  wire  logic [7:0]            acc_i,
  input  wire  logic [7:0]            reg_first_i,
  input  wire  logic [7:0]            reg_second_i,
  input  wire  logic [7:0]            sfr_i,
  input  wire  logic [7:0]            index_register_i,
  input  wire  logic [7:0]            page_offset_register_i,
  input  wire  logic [15:0]           pointer_pair_one_i,
  input  wire  logic [15:0]           pointer_pair_two_i,
  // Memory port
  output logic                        mem_req_o,
  output logic                        mem_we_o,
  output logic [15:0]                 mem_addr_o,
  output logic [7:0]                  mem_wdata_o,
  input  wire  logic                  mem_ack_i,
  input  wire  logic [7:0]            mem_rdata_i,
  // Completion and write back
  output logic                        done_o,
  output logic                        addr_err_o,
  output logic [7:0]                  result_o,
  output lca_pkg::lca_dest_type       wb_dest_o,
  // Flags
  output logic                        zero_flag_o,
  output logic                        auxiliary_carry_flag_o,
  output logic                        carry_flag_o
);

  lca_pkg::lca_state_type state_reg, state_next;
  lca_pkg::lca_op_type    op_reg,    op_next;
  lca_pkg::lca_mode_type  mode_reg,  mode_next;
  lca_pkg::lca_dest_type  dest_reg,  dest_next;
  logic [7:0]             a_reg,     a_next;
  logic [7:0]             b_reg,     b_next;
  logic [15:0]            addr_reg,  addr_next;
  logic [7:0]             res_reg,   res_next;
  logic                   z_reg,     z_next;
  logic                   aux_reg,   aux_next;
  logic                   carry_reg, carry_next;
  logic                   done_reg,  done_next;
  logic                   err_reg,   err_next;
  logic                   take;

  lca_alu_if alu_bus ();

  lca_alu_core lca_alu_core_i (
    .alu (alu_bus.core)
  );

  assign alu_bus.op  = op_reg;
  assign alu_bus.opa = a_reg;
  assign alu_bus.opb = b_reg;

  assign take        = req_valid_i && (state_reg == lca_pkg::ST_IDLE);
  assign req_ready_o = (state_reg == lca_pkg::ST_IDLE);
  assign mem_req_o   = (state_reg == lca_pkg::ST_FETCH) || (state_reg == lca_pkg::ST_STORE);
  assign mem_we_o    = (state_reg == lca_pkg::ST_STORE);
  assign mem_addr_o  = addr_reg;
  assign mem_wdata_o = res_reg;
  assign done_o      = done_reg;
  assign addr_err_o  = err_reg;
  assign result_o    = res_reg;
  assign wb_dest_o   = dest_reg;
  assign zero_flag_o            = z_reg;
  assign auxiliary_carry_flag_o = aux_reg;
  assign carry_flag_o           = carry_reg;

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    mode_next  = mode_reg;
    dest_next  = dest_reg;
    a_next     = a_reg;
    b_next     = b_reg;
    addr_next  = addr_reg;
    res_next   = res_reg;
    z_next     = z_reg;
    aux_next   = aux_reg;
    carry_next = carry_reg;
    done_next  = 1'b0;
    err_next   = 1'b0;
    unique case (state_reg)
      lca_pkg::ST_IDLE: begin
        if (take) begin
          op_next   = req_op_i;
          mode_next = req_mode_i;
          a_next    = acc_i;
          b_next    = req_imm_i;
          addr_next = req_word_i;
          unique case (req_mode_i)
            lca_pkg::M_REG: begin
              a_next = reg_first_i;
              b_next = reg_second_i;
            end
            lca_pkg::M_SFR_SRC: b_next = sfr_i;
            lca_pkg::M_SFR_DST: a_next = sfr_i;
            lca_pkg::M_PAGE: addr_next = {lca_pkg::PAGE_HI, page_offset_register_i};
            lca_pkg::M_PTR1: addr_next = pointer_pair_one_i;
            lca_pkg::M_PTR2: addr_next = pointer_pair_two_i;
            lca_pkg::M_INDEX: addr_next = req_word_i + {8'h00, index_register_i};
            default: ;
          endcase
          if (((req_mode_i == lca_pkg::M_SADDR_SRC) || (req_mode_i == lca_pkg::M_SADDR_DST))
              && !lca_pkg::lca_in_saddr(req_word_i)) begin
            err_next  = 1'b1;
            done_next = 1'b1;
            dest_next = lca_pkg::DST_NONE;
          end else if (lca_pkg::lca_is_mem(req_mode_i)) begin
            state_next = lca_pkg::ST_FETCH;
          end else begin
            state_next = lca_pkg::ST_EXEC;
          end
        end
      end
      lca_pkg::ST_FETCH: begin
        if (mem_ack_i) begin
          if (mode_reg == lca_pkg::M_SADDR_DST) begin
            a_next = mem_rdata_i;
          end else begin
            b_next = mem_rdata_i;
          end
          state_next = lca_pkg::ST_EXEC;
        end
      end
      lca_pkg::ST_EXEC: begin
        res_next = alu_bus.res;
        z_next   = alu_bus.zero;
        if (alu_bus.upd_carries) begin
          carry_next = alu_bus.borrow;
          aux_next   = alu_bus.half_borrow;
        end
        if (op_reg == lca_pkg::COMPARE_OP) begin
          dest_next  = lca_pkg::DST_NONE;
          done_next  = 1'b1;
          state_next = lca_pkg::ST_IDLE;
        end else if (mode_reg == lca_pkg::M_SADDR_DST) begin
          state_next = lca_pkg::ST_STORE;
        end else begin
          unique case (mode_reg)
            lca_pkg::M_REG:     dest_next = lca_pkg::DST_REG;
            lca_pkg::M_SFR_DST: dest_next = lca_pkg::DST_SFR;
            default:            dest_next = lca_pkg::DST_ACC;
          endcase
          done_next  = 1'b1;
          state_next = lca_pkg::ST_IDLE;
        end
      end
      lca_pkg::ST_STORE: begin
        if (mem_ack_i) begin
          dest_next  = lca_pkg::DST_MEM;
          done_next  = 1'b1;
          state_next = lca_pkg::ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_reg <= lca_pkg::ST_IDLE;
      op_reg    <= lca_pkg::OP_AND;
      mode_reg  <= lca_pkg::M_IMM;
      dest_reg  <= lca_pkg::DST_NONE;
      a_reg     <= lca_pkg::BYTE_RST;
      b_reg     <= lca_pkg::BYTE_RST;
      addr_reg  <= lca_pkg::ADDR_RST;
      res_reg   <= lca_pkg::BYTE_RST;
      z_reg     <= lca_pkg::FLAG_RST;
      aux_reg   <= lca_pkg::FLAG_RST;
      carry_reg <= lca_pkg::FLAG_RST;
      done_reg  <= 1'b0;
      err_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      mode_reg  <= mode_next;
      dest_reg  <= dest_next;
      a_reg     <= a_next;
      b_reg     <= b_next;
      addr_reg  <= addr_next;
      res_reg   <= res_next;
      z_reg     <= z_next;
      aux_reg   <= aux_next;
      carry_reg <= carry_next;
      done_reg  <= done_next;
      err_reg   <= err_next;
    end
  end

  property p_and_mem;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC && op_reg == lca_pkg::OP_AND &&
       lca_pkg::lca_is_mem(mode_reg) && mode_reg != lca_pkg::M_SADDR_DST)
      |=> (res_reg == ($past(a_reg) & $past(b_reg))) && dest_reg == lca_pkg::DST_ACC && done_o;
  endproperty
  a_and_mem: assert property (p_and_mem) else $error("AND with memory wrong");

  property p_index_addr;
    @(posedge clk_i) disable iff (!nrst_i)
      (take && req_mode_i == lca_pkg::M_INDEX)
      |=> addr_reg == $past(req_word_i) + {8'h00, $past(index_register_i)};
  endproperty
  a_index_addr: assert property (p_index_addr) else $error("Indexed address wrong");

  property p_logic_keeps;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC && op_reg != lca_pkg::COMPARE_OP)
      |=> $stable(carry_reg) && $stable(aux_reg);
  endproperty
  a_logic_keeps: assert property (p_logic_keeps) else $error("Logic op changed carry");

  property p_imm_xor;
    @(posedge clk_i) disable iff (!nrst_i)
      (take && req_mode_i == lca_pkg::M_IMM && req_op_i == lca_pkg::OP_XOR)
      |=> ##1 res_reg == ($past(acc_i, 2) ^ $past(req_imm_i, 2)) && dest_reg == lca_pkg::DST_ACC;
  endproperty
  a_imm_xor: assert property (p_imm_xor) else $error("Immediate XOR wrong");

  property p_saddr_window;
    @(posedge clk_i) disable iff (!nrst_i)
      (take && req_mode_i == lca_pkg::M_SADDR_DST && !lca_pkg::lca_in_saddr(req_word_i))
      |=> addr_err_o && state_reg == lca_pkg::ST_IDLE && !mem_req_o;
  endproperty
  a_saddr_window: assert property (p_saddr_window) else $error("Window miss not refused");

  property p_page;
    @(posedge clk_i) disable iff (!nrst_i)
      (take && req_mode_i == lca_pkg::M_PAGE)
      |=> mem_req_o && mem_addr_o == {lca_pkg::PAGE_HI, $past(page_offset_register_i)};
  endproperty
  a_page: assert property (p_page) else $error("Page address wrong");

  property p_sfr_wb;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC && mode_reg == lca_pkg::M_SFR_DST &&
       op_reg != lca_pkg::COMPARE_OP)
      |=> done_o && dest_reg == lca_pkg::DST_SFR;
  endproperty
  a_sfr_wb: assert property (p_sfr_wb) else $error("Special register not written");

  // A new request may be taken while done stands, so only a store and a write back are ruled out
  property p_compare_nowrite;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC && op_reg == lca_pkg::COMPARE_OP)
      |=> (dest_reg == lca_pkg::DST_NONE && !mem_we_o) [*2];
  endproperty
  a_compare_nowrite: assert property (p_compare_nowrite) else $error("Compare stored");

  property p_compare_carry;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC && op_reg == lca_pkg::COMPARE_OP)
      |=> carry_reg == ($past(a_reg) < $past(b_reg))
          && aux_reg == ($past(a_reg[3:0]) < $past(b_reg[3:0]));
  endproperty
  a_compare_carry: assert property (p_compare_carry) else $error("Compare flags wrong");

  property p_zero;
    @(posedge clk_i) disable iff (!nrst_i)
      (state_reg == lca_pkg::ST_EXEC) |=> z_reg == (res_reg == lca_pkg::BYTE_RST);
  endproperty
  a_zero: assert property (p_zero) else $error("Zero flag wrong");

endmodule : lca_exec
`default_nettype wire

// *** sim/lca_exec_bench.sv ***
// Purpose: self-checking bench of the logic and compare sequencer
// Assumes: bench answers the memory port itself, ack after a set wait
// Notes:   expected values are rebuilt here from plain byte arithmetic
`timescale 1ns/100ps
`default_nettype none
module lca_exec_bench;
  logic                  clk_i = 1'b0;
  logic                  nrst_i = 1'b0;
  logic                  req_valid_i = 1'b0;
  logic                  req_ready_o;
  lca_pkg::lca_op_type   req_op_i = lca_pkg::OP_AND;
  lca_pkg::lca_mode_type req_mode_i = lca_pkg::M_IMM;
  logic [7:0]            req_imm_i = 8'h00;
  logic [15:0]           req_word_i = 16'h0000;
  logic [7:0]            acc_i = 8'h00;
  logic [7:0]            reg_first_i = 8'h00;
  logic [7:0]            reg_second_i = 8'h00;
  logic [7:0]            sfr_i = 8'h00;
  logic [7:0]            index_register_i = 8'h00;
  logic [7:0]            page_offset_register_i = 8'h00;
  logic [15:0]           pointer_pair_one_i = 16'h0000;
  logic [15:0]           pointer_pair_two_i = 16'h0000;
  logic                  mem_req_o;
  logic                  mem_we_o;
  logic [15:0]           mem_addr_o;
  logic [7:0]            mem_wdata_o;
  logic                  mem_ack_i = 1'b0;
  logic [7:0]            mem_rdata_i = 8'h00;
  logic                  done_o;
  logic                  addr_err_o;
  logic [7:0]            result_o;
  lca_pkg::lca_dest_type wb_dest_o;
  logic                  zero_flag_o;
  logic                  auxiliary_carry_flag_o;
  logic                  carry_flag_o;
  int                    errors = 0;
  int                    tests_run = 0;
  int                    mem_wait = 0;
  int                    lat;
  logic [7:0]            mem_byte = 8'h00;
  logic                  rd_seen, wr_seen, err_seen;
  logic [15:0]           rd_addr, wr_addr;
  logic [7:0]            wr_data;
  logic                  exp_z = 1'b0, exp_aux = 1'b0, exp_carry = 1'b0;
  lca_pkg::lca_op_type   ops [3] = '{lca_pkg::OP_AND, lca_pkg::OP_OR, lca_pkg::OP_XOR};

  lca_exec lca_exec_i (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
    .req_op_i(req_op_i), .req_mode_i(req_mode_i), .req_imm_i(req_imm_i),
    .req_word_i(req_word_i), .acc_i(acc_i), .reg_first_i(reg_first_i),
    .reg_second_i(reg_second_i), .sfr_i(sfr_i), .index_register_i(index_register_i),
    .page_offset_register_i(page_offset_register_i),
    .pointer_pair_one_i(pointer_pair_one_i), .pointer_pair_two_i(pointer_pair_two_i),
    .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .done_o(done_o), .addr_err_o(addr_err_o), .result_o(result_o), .wb_dest_o(wb_dest_o),
    .zero_flag_o(zero_flag_o), .auxiliary_carry_flag_o(auxiliary_carry_flag_o),
    .carry_flag_o(carry_flag_o)
  );

  always #12.5 clk_i = ~clk_i;

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic give_verdict();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : give_verdict

  task automatic chk_dest(input lca_pkg::lca_dest_type d);
    chk("dest", 16'(d), 16'(wb_dest_o));
  endtask : chk_dest

  // One request, then serve the memory port until done; the wait stresses held requests
  task automatic run_op(input lca_pkg::lca_op_type op, input lca_pkg::lca_mode_type md,
                        input logic [7:0] imm, input logic [15:0] word);
    logic [15:0] a0;
    req_op_i = op;
    req_mode_i = md;
    req_imm_i = imm;
    req_word_i = word;
    req_valid_i = 1'b1;
    rd_seen = 1'b0;
    wr_seen = 1'b0;
    lat = 0;
    @(posedge clk_i);
    #1;
    req_valid_i = 1'b0;
    // Busy until the answer: no second request may be taken meanwhile
    if (done_o !== 1'b1) begin
      chk("busy", 16'h0000, 16'(req_ready_o));
    end
    while (done_o !== 1'b1 && lat < 40) begin
      if (mem_req_o === 1'b1) begin
        a0 = mem_addr_o;
        repeat (mem_wait) begin
          @(posedge clk_i);
          #1;
        end
        chk("addr held", a0, mem_addr_o);
        if (mem_we_o === 1'b1) begin
          wr_seen = 1'b1;
          wr_addr = mem_addr_o;
          wr_data = mem_wdata_o;
        end else begin
          rd_seen = 1'b1;
          rd_addr = mem_addr_o;
        end
        mem_rdata_i = mem_byte;
        mem_ack_i = 1'b1;
        @(posedge clk_i);
        #1;
        mem_ack_i = 1'b0;
        mem_rdata_i = ~mem_byte;
      end else begin
        @(posedge clk_i);
        #1;
      end
      lat++;
    end
    err_seen = addr_err_o;
    chk("done", 16'h0001, 16'(done_o));
    chk("ready again", 16'h0001, 16'(req_ready_o));
  endtask : run_op

  function automatic logic [7:0] lg(input lca_pkg::lca_op_type op, input logic [7:0] a, b);
    case (op)
      lca_pkg::OP_AND: lg = a & b;
      lca_pkg::OP_OR:  lg = a | b;
      default:         lg = a ^ b;
    endcase
  endfunction : lg

  task automatic flag_chk();
    chk("zero", 16'(exp_z), 16'(zero_flag_o));
    chk("aux carry", 16'(exp_aux), 16'(auxiliary_carry_flag_o));
    chk("carry", 16'(exp_carry), 16'(carry_flag_o));
  endtask : flag_chk

  task automatic lg_chk(input lca_pkg::lca_op_type op, input logic [7:0] a, b,
                        input lca_pkg::lca_dest_type d);
    logic [7:0] r;
    r = lg(op, a, b);
    exp_z = (r == 8'h00);
    chk("result", 16'(r), 16'(result_o));
    chk("no error", 16'h0000, 16'(err_seen));
    flag_chk();
    chk_dest(d);
  endtask : lg_chk

  task automatic compare_chk(input logic [7:0] a, b);
    logic [7:0] d;
    d = a - b;
    exp_z = (d == 8'h00);
    exp_carry = (a < b);
    exp_aux = (a[3:0] < b[3:0]);
    chk("difference", 16'(d), 16'(result_o));
    chk("no error", 16'h0000, 16'(err_seen));
    flag_chk();
    chk_dest(lca_pkg::DST_NONE);
  endtask : compare_chk

  task automatic t_reset();
    chk("ready", 16'h0001, 16'(req_ready_o));
    chk("mem req", 16'h0000, 16'(mem_req_o));
    chk("done idle", 16'h0000, 16'(done_o));
    chk("result", 16'h0000, 16'(result_o));
    flag_chk();
    chk_dest(lca_pkg::DST_NONE);
  endtask : t_reset

  task automatic t_compare_imm();
    logic [7:0] av [5] = '{8'h10, 8'h00, 8'h20, 8'hff, 8'h80};
    logic [7:0] bv [5] = '{8'h10, 8'h01, 8'h11, 8'h00, 8'h7f};
    for (int k = 0; k < 5; k++) begin
      acc_i = av[k];
      run_op(lca_pkg::COMPARE_OP, lca_pkg::M_IMM, bv[k], 16'h0000);
      compare_chk(av[k], bv[k]);
    end
  endtask : t_compare_imm

  task automatic t_logic_imm();
    logic [7:0] av [4] = '{8'h00, 8'hff, 8'h5a, 8'h0f};
    logic [7:0] bv [4] = '{8'hff, 8'hff, 8'ha5, 8'hf0};
    for (int i = 0; i < 3; i++) begin
      for (int j = 0; j < 4; j++) begin
        // Alternate carries set and clear so a logic op that touches them shows
        acc_i = 8'(j % 2);
        run_op(lca_pkg::COMPARE_OP, lca_pkg::M_IMM, 8'(1 - j % 2), 16'h0000);
        compare_chk(8'(j % 2), 8'(1 - j % 2));
        acc_i = av[j];
        run_op(ops[i], lca_pkg::M_IMM, bv[j], 16'h0000);
        chk("latency", 16'h0001, 16'(lat));
        lg_chk(ops[i], av[j], bv[j], lca_pkg::DST_ACC);
      end
    end
  endtask : t_logic_imm

  task automatic t_mem_src();
    lca_pkg::lca_mode_type md [5] = '{lca_pkg::M_PAGE, lca_pkg::M_PTR1, lca_pkg::M_PTR2,
                                      lca_pkg::M_INDEX, lca_pkg::M_SADDR_SRC};
    logic [15:0] wd [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h12f0, 16'hfe80};
    logic [15:0] ea [5] = '{16'hfeff, 16'h1234, 16'hfedc, 16'h1310, 16'hfe80};
    page_offset_register_i = 8'hff;
    pointer_pair_one_i = 16'h1234;
    pointer_pair_two_i = 16'hfedc;
    index_register_i = 8'h20;
    acc_i = 8'h3c;
    for (int k = 0; k < 5; k++) begin
      mem_wait = k;
      mem_byte = 8'ha6 + 8'(k);
      run_op(ops[k % 3], md[k], 8'h00, wd[k]);
      chk("read addr", ea[k], rd_addr);
      chk("no write", 16'h0000, 16'(wr_seen));
      lg_chk(ops[k % 3], 8'h3c, mem_byte, lca_pkg::DST_ACC);
    end
    mem_byte = 8'h3c;
    run_op(lca_pkg::COMPARE_OP, lca_pkg::M_PTR1, 8'h00, 16'h0000);
    chk("no write", 16'h0000, 16'(wr_seen));
    compare_chk(8'h3c, 8'h3c);
    mem_wait = 0;
  endtask : t_mem_src

  task automatic t_reg_sfr();
    reg_first_i = 8'hc3;
    reg_second_i = 8'h3c;
    sfr_i = 8'h81;
    acc_i = 8'h18;
    for (int i = 0; i < 3; i++) begin
      run_op(ops[i], lca_pkg::M_REG, 8'h00, 16'h0000);
      lg_chk(ops[i], 8'hc3, 8'h3c, lca_pkg::DST_REG);
      run_op(ops[i], lca_pkg::M_SFR_SRC, 8'h00, 16'h0000);
      lg_chk(ops[i], 8'h18, 8'h81, lca_pkg::DST_ACC);
    end
    for (int i = 1; i < 3; i++) begin
      run_op(ops[i], lca_pkg::M_SFR_DST, 8'h81, 16'h0000);
      lg_chk(ops[i], 8'h81, 8'h81, lca_pkg::DST_SFR);
    end
    run_op(lca_pkg::COMPARE_OP, lca_pkg::M_SFR_DST, 8'h82, 16'h0000);
    compare_chk(8'h81, 8'h82);
  endtask : t_reg_sfr

  task automatic t_saddr();
    logic [15:0] inw [2] = '{16'hfe20, 16'hff1f};
    logic [15:0] outw [2] = '{16'hfe1f, 16'hff20};
    mem_wait = 1;
    mem_byte = 8'h0f;
    for (int i = 0; i < 3; i++) begin
      run_op(ops[i], lca_pkg::M_SADDR_DST, 8'hf3, inw[i % 2]);
      chk("read addr", inw[i % 2], rd_addr);
      chk("write addr", inw[i % 2], wr_addr);
      chk("write data", 16'(lg(ops[i], 8'h0f, 8'hf3)), 16'(wr_data));
      lg_chk(ops[i], 8'h0f, 8'hf3, lca_pkg::DST_MEM);
    end
    mem_byte = 8'h05;
    run_op(lca_pkg::COMPARE_OP, lca_pkg::M_SADDR_DST, 8'h06, 16'hff1f);
    chk("no write", 16'h0000, 16'(wr_seen));
    compare_chk(8'h05, 8'h06);
    for (int k = 0; k < 4; k++) begin
      run_op(ops[k % 3], k < 2 ? lca_pkg::M_SADDR_DST : lca_pkg::M_SADDR_SRC, 8'h00,
             outw[k % 2]);
      chk("window error", 16'h0001, 16'(err_seen));
      chk("no access", 16'h0000, 16'(rd_seen | wr_seen));
      chk("error latency", 16'h0000, 16'(lat));
      flag_chk();
      chk_dest(lca_pkg::DST_NONE);
      // A refused request ends at once; let the edge pass before valid rises again
      @(posedge clk_i);
      #1;
    end
    mem_wait = 0;
  endtask : t_saddr

  initial begin
    repeat (5) @(posedge clk_i);
    #1;
    t_reset();
    nrst_i = 1'b1;
    t_compare_imm();
    t_logic_imm();
    t_mem_src();
    t_reg_sfr();
    t_saddr();
    give_verdict();
  end

  // About five thousand cycles, over thirty times what the scenarios need
  initial begin
    #125000;
    errors++;
    give_verdict();
  end
endmodule : lca_exec_bench
`default_nettype wire
